// ### shc_spi_host_controller.sv
// Notes on behaviour
// RULE1: Two-bit interrupt line select: codes pick lines 3, 4, 5, 10; read/write.
// RULE2: Serial clock is bus clock divided by 32, 16, 8 or 4 per rate field.
// RULE3: With interrupt enable clear, no interrupt line is ever driven.
// RULE4: Direction bit 0 shifts most significant bit first, 1 least first.
// RULE5: Read-only flag mirrors the expansion interrupt input; reads 0 when unasserted.
// RULE6: Enable set and expansion interrupt asserted drives the selected line.
// RULE7: Busy flag reads 1 while a frame is shifting, 0 when idle.
// RULE8: Four data bytes form one word; byte zero is least significant.
// RULE9: Writing the top data byte starts a frame; auto mode asserts chip select.
// RULE10: Msb-first sends top bit of byte three; received bits enter bit zero.
// RULE11: Lsb-first sends bit zero first; received bits enter top of byte three.
// RULE12: Loopback bit feeds serial output into serial input; output still driven.
// RULE13: Write-only converter bit 4 drives the DAC load strobe.
// RULE14: Read-only converter bit 2 reflects the ADC busy input.
// RULE15: Write-only converter bit 0 drives the ADC conversion start.
// RULE16: Converter reserved bits ignore writes and read as zero.
// RULE17: Frame length field gives 8, 16, 24 or 32 bits in both modes.
// RULE18: Manual bit 0 gives automatic chip select; 1 follows the select field.
// RULE19: Select code 0 none, 1-4 expansion 0-3, 5 ADC, 6 I/O, 7 DAC.
// RULE20: Polarity bit sets sclk idle level; phase bit picks the sampling edge.
// RULE21: Busy rises the cycle after the top byte write; falls after frame ends.
// RULE22: Auto mode releases chip select after the last edge; sclk returns idle.
`include "shc_params.svh"

module shc_spi_host_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic cmd_ready,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  output logic [6:0] cs_n,
  input wire logic expansion_interrupt_n,
  output logic [3:0] irq_lines,
  output logic dac_load_strobe,
  output logic adc_convert_start,
  input wire logic adc_busy_in
);

  logic [7:0] ctrl_q;
  logic [7:0] status_cfg_q;
  logic [31:0] word_q;
  logic loopback_enable_q;
  logic dac_q;
  logic adc_q;
  logic [7:0] rdata_q;
  logic busy_q;
  logic cmd_ready_q;
  logic sclk_q;
  logic mosi_q;
  logic rx_bit_q;
  logic [6:0] cs_n_q;
  logic [3:0] irq_q;
  logic [31:0] sr_q;
  logic [5:0] edges_q;
  shc_pkg::shc_state_t state_q;

  logic cpol;
  logic cpha;
  logic manual_chip_select;
  logic [2:0] cs_code;
  logic [1:0] frame_length_select;
  logic [1:0] irq_line_select;
  logic [1:0] sclk_rate_select;
  logic hw_interrupt_enable;
  logic lsb_first_select;
  logic ext_interrupt_flag;
  logic [5:0] last_edge;
  logic rx_in;
  logic tick;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic frame_done;
  logic leading;
  logic [31:0] sr_next;
  logic [2:0] cs_active_code;

  assign cpol = ctrl_q[`SHC_CTL_CPOL];
  assign cpha = ctrl_q[`SHC_CTL_CPHA];
  assign frame_length_select = ctrl_q[`SHC_CTL_LEN_HI:`SHC_CTL_LEN_LO];
  assign manual_chip_select = ctrl_q[`SHC_CTL_MAN];
  assign cs_code = ctrl_q[`SHC_CTL_CS_HI:`SHC_CTL_CS_LO];
  assign irq_line_select = status_cfg_q[`SHC_ST_IRQSEL_HI:`SHC_ST_IRQSEL_LO];
  assign sclk_rate_select = status_cfg_q[`SHC_ST_RATE_HI:`SHC_ST_RATE_LO];
  assign hw_interrupt_enable = status_cfg_q[`SHC_ST_HWEN];
  assign lsb_first_select = status_cfg_q[`SHC_ST_LSB];
  assign ext_interrupt_flag = !expansion_interrupt_n; // see RULE5

  // Frame of 8 x (code + 1) bits takes twice as many clock edges.
  assign last_edge = {frame_length_select, 4'hF}; // see RULE17
  assign rx_in = loopback_enable_q ? mosi_q : miso; // see RULE12
  assign push = bus_wr && (bus_addr == `SHC_OFF_DATA3) && fifo_in_ready; // see RULE9
  assign fifo_out_ready = (state_q == shc_pkg::SHC_IDLE);
  assign frame_done = (state_q == shc_pkg::SHC_TAIL) && tick;
  assign leading = !edges_q[0];

  function automatic logic tx_bit(input logic lsb, input logic [31:0] v);
    tx_bit = lsb ? v[0] : v[31]; // see RULE4
  endfunction : tx_bit

  function automatic logic [31:0] shift_word(input logic lsb, input logic [31:0] v,
                                             input logic b);
    shift_word = lsb ? {b, v[31:1]} : {v[30:0], b}; // see RULE10, RULE11
  endfunction : shift_word

  function automatic logic [6:0] cs_decode(input logic [2:0] code);
    cs_decode = (code == 3'h0) ? `SHC_CS_NONE : ~(7'h01 << (code - 3'h1)); // see RULE19
  endfunction : cs_decode

  assign sr_next = shift_word(lsb_first_select, sr_q, cpha ? rx_in : rx_bit_q);
  assign cs_active_code = manual_chip_select ? cs_code :
                          ((state_q != shc_pkg::SHC_IDLE) ? cs_code : 3'h0); // see RULE18

  shc_fifo #(
    .WIDTH(`SHC_FIFO_WIDTH),
    .DEPTH(`SHC_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({bus_wdata, word_q[23:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  shc_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .run(state_q != shc_pkg::SHC_IDLE),
    .rate(sclk_rate_select), // see RULE2
    .tick(tick)
  );

  // Configuration registers written by software.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `SHC_RST_BYTE;
      status_cfg_q <= `SHC_RST_BYTE;
      loopback_enable_q <= 1'b0;
      dac_q <= 1'b0;
      adc_q <= 1'b0;
    end else if (bus_wr) begin
      case (bus_addr)
        `SHC_OFF_CONTROL: ctrl_q <= bus_wdata;
        `SHC_OFF_STATUS: status_cfg_q <= {bus_wdata[7:2], 2'b00}; // see RULE1
        `SHC_OFF_DEBUG: loopback_enable_q <= bus_wdata[`SHC_DBG_LOOP];
        `SHC_OFF_CONV: begin
          dac_q <= bus_wdata[`SHC_CONV_DAC]; // see RULE13
          adc_q <= bus_wdata[`SHC_CONV_ADCSTART]; // see RULE15
        end
        default: begin
        end
      endcase
    end
  end

  // Data word: byte writes, then the received word once a frame ends.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_q <= `SHC_RST_WORD;
    end else begin
      if (frame_done) begin
        word_q <= sr_q;
      end
      if (bus_wr) begin
        case (bus_addr)
          `SHC_OFF_DATA0: word_q[7:0] <= bus_wdata; // see RULE8
          `SHC_OFF_DATA1: word_q[15:8] <= bus_wdata;
          `SHC_OFF_DATA2: word_q[23:16] <= bus_wdata;
          `SHC_OFF_DATA3: word_q[31:24] <= bus_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // Busy: a new start wins over the end of the previous frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (push) begin
      busy_q <= 1'b1; // see RULE21
    end else if (frame_done && !fifo_out_valid) begin
      busy_q <= 1'b0; // see RULE7
    end
  end

  // Serial engine.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= shc_pkg::SHC_IDLE;
      sr_q <= `SHC_RST_WORD;
      edges_q <= 6'h00;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      rx_bit_q <= 1'b0;
    end else begin
      case (state_q)
        shc_pkg::SHC_IDLE: begin
          sclk_q <= cpol; // see RULE20
          edges_q <= 6'h00;
          if (fifo_out_valid) begin
            sr_q <= fifo_out_data;
            mosi_q <= tx_bit(lsb_first_select, fifo_out_data);
            state_q <= shc_pkg::SHC_LEAD;
          end
        end
        shc_pkg::SHC_LEAD: begin
          if (tick) begin
            state_q <= shc_pkg::SHC_SHIFT;
          end
        end
        shc_pkg::SHC_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            edges_q <= edges_q + 6'h01;
            if (leading) begin
              if (!cpha) begin
                rx_bit_q <= rx_in; // see RULE20
              end else begin
                mosi_q <= tx_bit(lsb_first_select, sr_q);
              end
            end else begin
              sr_q <= sr_next;
              if (!cpha) begin
                mosi_q <= tx_bit(lsb_first_select, sr_next);
              end
            end
            if (edges_q == last_edge) begin
              state_q <= shc_pkg::SHC_TAIL; // see RULE17
            end
          end
        end
        shc_pkg::SHC_TAIL: begin
          sclk_q <= cpol; // see RULE22
          if (tick) begin
            state_q <= shc_pkg::SHC_IDLE;
          end
        end
        default: begin
          state_q <= shc_pkg::SHC_IDLE;
        end
      endcase
    end
  end

  // Pin side registers: chip selects and interrupt lines.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n_q <= `SHC_CS_NONE;
      irq_q <= 4'h0;
      cmd_ready_q <= 1'b0;
    end else begin
      cs_n_q <= cs_decode(cs_active_code); // see RULE9, RULE22
      cmd_ready_q <= fifo_in_ready;
      if (hw_interrupt_enable && ext_interrupt_flag) begin
        irq_q <= 4'h1 << irq_line_select; // see RULE6
      end else begin
        irq_q <= 4'h0; // see RULE3
      end
    end
  end

  // Register read port.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `SHC_RST_BYTE;
    end else if (bus_rd) begin
      case (bus_addr)
        `SHC_OFF_CONTROL: rdata_q <= ctrl_q;
        `SHC_OFF_STATUS: rdata_q <= {status_cfg_q[7:2], ext_interrupt_flag, busy_q};
        `SHC_OFF_DATA0: rdata_q <= word_q[7:0];
        `SHC_OFF_DATA1: rdata_q <= word_q[15:8];
        `SHC_OFF_DATA2: rdata_q <= word_q[23:16];
        `SHC_OFF_DATA3: rdata_q <= word_q[31:24];
        `SHC_OFF_DEBUG: rdata_q <= {6'h00, loopback_enable_q, 1'b0};
        `SHC_OFF_CONV: rdata_q <= {5'h00, adc_busy_in, 2'b00}; // see RULE14, RULE16
        default: rdata_q <= `SHC_UNMAPPED;
      endcase
    end
  end

  assign bus_rdata = rdata_q;
  assign cmd_ready = cmd_ready_q;
  assign sclk = sclk_q;
  assign mosi = mosi_q;
  assign cs_n = cs_n_q;
  assign irq_lines = irq_q;
  assign dac_load_strobe = dac_q;
  assign adc_convert_start = adc_q;

  default clocking shc_cb @(posedge clk);
  endclocking

  default disable iff (rst);

  sequence s_idle_auto2;
    (state_q == shc_pkg::SHC_IDLE && !manual_chip_select) ##1
    (state_q == shc_pkg::SHC_IDLE && !manual_chip_select);
  endsequence

  sequence s_idle_steady;
    (state_q == shc_pkg::SHC_IDLE) ##1 (state_q == shc_pkg::SHC_IDLE && $stable(cpol));
  endsequence

  sequence s_last_edge;
    (state_q == shc_pkg::SHC_SHIFT && tick && edges_q == last_edge);
  endsequence

  sequence s_top_write;
    push ##1 1'b1;
  endsequence

  busy_set_a: assert property (s_top_write |-> busy_q) // see RULE21
    else $error("busy not set after top byte write");

  irq_gated_a: assert property (!hw_interrupt_enable |=> irq_q == 4'h0) // see RULE3
    else $error("interrupt line driven while disabled");

  irq_select_a: assert property ((hw_interrupt_enable && ext_interrupt_flag)
    |=> irq_q == (4'h1 << $past(irq_line_select))) // see RULE6
    else $error("wrong interrupt line driven");

  sclk_idle_a: assert property (s_idle_steady |-> sclk_q == cpol) // see RULE20
    else $error("serial clock not at idle level");

  cs_release_a: assert property (s_idle_auto2 |-> cs_n_q == `SHC_CS_NONE) // see RULE22
    else $error("chip select held while idle in auto mode");

  cs_manual_a: assert property ((manual_chip_select ##1 $stable(ctrl_q))
    |-> cs_n_q == cs_decode(cs_code)) // see RULE18
    else $error("manual chip select does not follow field");

  frame_end_a: assert property (s_last_edge |=> state_q == shc_pkg::SHC_TAIL
    ##[2:16] state_q == shc_pkg::SHC_IDLE) // see RULE17
    else $error("frame did not end after its last edge");

  loop_sample_a: assert property ((loopback_enable_q && !cpha && state_q == shc_pkg::SHC_SHIFT
    && tick && leading) |=> rx_bit_q == $past(mosi_q)) // see RULE12
    else $error("loopback sample differs from output");

  conv_write_a: assert property ((bus_wr && bus_addr == `SHC_OFF_CONV)
    |=> dac_q == $past(bus_wdata[`SHC_CONV_DAC])
        && adc_q == $past(bus_wdata[`SHC_CONV_ADCSTART])) // see RULE13
    else $error("converter strobes not updated");

  busy_read_a: assert property ((bus_rd && bus_addr == `SHC_OFF_STATUS)
    |=> rdata_q[`SHC_ST_BUSY] == $past(busy_q)) // see RULE7
    else $error("status read does not show busy");

endmodule : shc_spi_host_controller

// ### shc_params.svh
`ifndef SHC_PARAMS_SVH
`define SHC_PARAMS_SVH

// Register offsets within the block's byte window.
`define SHC_OFF_CONTROL 4'h8
`define SHC_OFF_STATUS 4'h9
`define SHC_OFF_DATA0 4'hA
`define SHC_OFF_DATA1 4'hB
`define SHC_OFF_DATA2 4'hC
`define SHC_OFF_DATA3 4'hD
`define SHC_OFF_DEBUG 4'hE
`define SHC_OFF_CONV 4'hF

// Control register fields.
`define SHC_CTL_CPOL 7
`define SHC_CTL_CPHA 6
`define SHC_CTL_LEN_HI 5
`define SHC_CTL_LEN_LO 4
`define SHC_CTL_MAN 3
`define SHC_CTL_CS_HI 2
`define SHC_CTL_CS_LO 0

// Status and configuration register fields.
`define SHC_ST_IRQSEL_HI 7
`define SHC_ST_IRQSEL_LO 6
`define SHC_ST_RATE_HI 5
`define SHC_ST_RATE_LO 4
`define SHC_ST_HWEN 3
`define SHC_ST_LSB 2
`define SHC_ST_EXT 1
`define SHC_ST_BUSY 0

// Debug register and converter strobe register fields.
`define SHC_DBG_LOOP 1
`define SHC_CONV_DAC 4
`define SHC_CONV_ADCBUSY 2
`define SHC_CONV_ADCSTART 0

// Reset values and idle levels.
`define SHC_RST_BYTE 8'h00
`define SHC_RST_WORD 32'h00000000
`define SHC_CS_NONE 7'h7F
`define SHC_UNMAPPED 8'h00

// Half periods of the serial clock, in bus clock cycles, for each rate code.
`define SHC_HALF_DIV32 5'h10
`define SHC_HALF_DIV16 5'h08
`define SHC_HALF_DIV8 5'h04
`define SHC_HALF_DIV4 5'h02

// Transmit word queue geometry.
`define SHC_FIFO_WIDTH 32
`define SHC_FIFO_DEPTH 16

`endif

// ### shc_pkg.sv
package shc_pkg;

  typedef enum logic [1:0] {
    SHC_IDLE = 2'b00,
    SHC_LEAD = 2'b01,
    SHC_SHIFT = 2'b10,
    SHC_TAIL = 2'b11
  } shc_state_t;

  typedef enum logic [1:0] {
    SHC_RATE_DIV32 = 2'b00,
    SHC_RATE_DIV16 = 2'b01,
    SHC_RATE_DIV8 = 2'b10,
    SHC_RATE_DIV4 = 2'b11
  } shc_rate_t;

endpackage : shc_pkg

// ### shc_fifo.sv
module shc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic do_push;
  logic do_pop;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : shc_fifo

// ### shc_clk_div.sv
`include "shc_params.svh"

module shc_clk_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] rate,
  output logic tick
);

  logic [4:0] cnt_q;
  logic [4:0] half;

  always_comb begin
    case (shc_pkg::shc_rate_t'(rate))
      shc_pkg::SHC_RATE_DIV32: half = `SHC_HALF_DIV32;
      shc_pkg::SHC_RATE_DIV16: half = `SHC_HALF_DIV16;
      shc_pkg::SHC_RATE_DIV8: half = `SHC_HALF_DIV8;
      default: half = `SHC_HALF_DIV4;
    endcase
  end

  // One pulse per half period of the serial clock; held in reset while idle.
  assign tick = run && (cnt_q == half - 5'h01);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (!run || tick) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

endmodule : shc_clk_div

// ### shc_peer_model.sv
module shc_peer_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [6:0] cs_n,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] reply;
  logic [31:0] captured;
  logic [31:0] sh_q;
  int frames;
  logic sel;
  logic rose;

  assign sel = ~&cs_n;

  initial begin
    reply = 32'h00000000;
    captured = 32'h00000000;
    sh_q = 32'h00000000;
    frames = 0;
    rose = 1'b0;
    miso = 1'b0;
  end

  // The first reply bit is presented as soon as the peripheral is chosen.
  always @(posedge sel) begin
    captured = 32'h00000000;
    rose = 1'b0;
    sh_q = reply;
    miso = reply[31];
  end

  // Host data is taken on the rising clock edge.
  always @(posedge sclk) begin
    if (sel) begin
      captured = {captured[30:0], mosi};
      rose = 1'b1;
    end
  end

  // The reply advances on a falling edge that follows a sampling edge.
  always @(negedge sclk) begin
    if (sel && rose) begin
      sh_q = {sh_q[30:0], 1'b0};
      miso = sh_q[31];
    end
  end

  // A released line does not keep its last value, so a late sample shows up.
  always @(negedge sel) begin
    frames++;
    miso = ~miso;
  end
endmodule : shc_peer_model

// ### shc_tb.sv
`include "shc_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic cmd_ready;
  logic sclk;
  logic mosi;
  logic miso;
  logic [6:0] cs_n;
  logic expansion_interrupt_n = 1'b1;
  logic [3:0] irq_lines;
  logic dac_load_strobe;
  logic adc_convert_start;
  logic adc_busy_in = 1'b1;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int last = 0;
  int per = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc++;
  always @(posedge sclk) begin
    per = cyc - last;
    last = cyc;
  end

  shc_spi_host_controller u_dut (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cmd_ready(cmd_ready), .sclk(sclk),
    .mosi(mosi), .miso(miso), .cs_n(cs_n), .expansion_interrupt_n(expansion_interrupt_n),
    .irq_lines(irq_lines), .dac_load_strobe(dac_load_strobe),
    .adc_convert_start(adc_convert_start), .adc_busy_in(adc_busy_in)
  );

  shc_peer_model u_peer (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    @(negedge clk);
    v = bus_rdata;
  endtask : rd

  task automatic wait_idle;
    logic [7:0] v;
    int k;
    k = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && k < 3000) begin
      rd(`SHC_OFF_STATUS, v);
      k++;
    end
    chk(k < 3000, 1'b1);
  endtask : wait_idle

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  function automatic logic [63:0] exp_frame(input logic [31:0] w, input logic [31:0] rx,
                                            input int n, input logic lsb, input logic lp);
    logic [31:0] tx;
    logic b;
    tx = 32'h00000000;
    for (int k = 0; k < n; k++) begin
      b = lsb ? w[0] : w[31];
      tx = {tx[30:0], b};
      w = lsb ? {(lp ? b : rx[31-k]), w[31:1]} : {w[30:0], (lp ? b : rx[31-k])};
    end
    return {tx, w};
  endfunction : exp_frame

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [31:0] w;
    logic [31:0] got;
    logic [63:0] e;
    logic [1:0] len;
    logic [1:0] rate;
    logic lsb;
    logic lp;
    logic m;
    int n;
    int f0;
    void'($urandom(2));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(cs_n, 7'h7F);
    chk(cmd_ready, 1'b1);
    rd(`SHC_OFF_STATUS, d);
    chk(d, 8'h00);
    rd(4'h3, d);
    chk(d, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(`SHC_OFF_CONTROL, 8'(8'h08 | c));
      rd(`SHC_OFF_CONTROL, d);
      chk(d, 8'(8'h08 | c));
      chk(cs_n, (c == 0) ? 7'h7F : 7'(~(7'h01 << (c - 1))));
    end
    wr(`SHC_OFF_CONTROL, 8'h80);
    chk(sclk, 1'b1);
    wr(`SHC_OFF_CONTROL, 8'h00);
    chk(sclk, 1'b0);
    $display("test selects done");
    expansion_interrupt_n = 1'b0;
    for (int k = 0; k < 8; k++) begin
      wr(`SHC_OFF_STATUS, {k[1:0], 2'b11, k[2], 3'b000});
      rd(`SHC_OFF_STATUS, d);
      chk(d, {k[1:0], 2'b11, k[2], 3'b010});
      chk(irq_lines, k[2] ? 4'(4'h1 << k[1:0]) : 4'h0);
    end
    expansion_interrupt_n = 1'b1;
    $display("test interrupts done");
    for (int k = 0; k < 2; k++) begin
      adc_busy_in = k[0];
      wr(`SHC_OFF_CONV, k[0] ? 8'hFF : 8'h00);
      rd(`SHC_OFF_CONV, d);
      chk({d[7:5], d[3:1], dac_load_strobe, adc_convert_start},
          {3'b000, 1'b0, k[0], 1'b0, k[0], k[0]});
    end
    $display("test converter done");
    for (int i = 0; i < 8; i++) begin
      rate = 2'(i % 4);
      len = (i == 0) ? 2'b11 : 2'($urandom % 4);
      lsb = (i >= 4);
      lp = (i == 7);
      m = (i == 2 || i == 5);
      w = $urandom;
      u_peer.reply = $urandom;
      wr(`SHC_OFF_CONTROL, {m, m, len, 4'b0110});
      wr(`SHC_OFF_STATUS, {2'b00, rate, 1'b0, lsb, 2'b00});
      wr(`SHC_OFF_DEBUG, {6'h00, lp, 1'b0});
      for (int b = 0; b < 4; b++) wr(4'(`SHC_OFF_DATA0 + b), w[8*b +: 8]);
      rd(`SHC_OFF_STATUS, d);
      chk(d[0], 1'b1);
      chk(cs_n, 7'h5F);
      wait_idle();
      repeat (2) @(negedge clk);
      chk({cs_n, sclk}, {7'h7F, m});
      chk(per, 32 >> rate);
      n = 8 * (int'(len) + 1);
      e = exp_frame(w, u_peer.reply, n, lsb, lp);
      chk(u_peer.captured, e[63:32]);
      for (int b = 0; b < 4; b++) begin
        rd(4'(`SHC_OFF_DATA0 + b), d);
        got[8*b +: 8] = d;
      end
      chk(got, e[31:0]);
      $display("test frame %0d done", i);
    end
    wr(`SHC_OFF_CONTROL, 8'h06);
    wr(`SHC_OFF_STATUS, 8'h10);
    wr(`SHC_OFF_DEBUG, 8'h00);
    f0 = u_peer.frames;
    n = 0;
    while (cmd_ready === 1'b1 && n < 40) begin
      wr(`SHC_OFF_DATA3, 8'(n));
      n++;
    end
    chk(cmd_ready, 1'b0);
    chk(n > 15 && n < 20, 1'b1);
    wait_idle();
    chk(cmd_ready, 1'b1);
    chk(u_peer.frames - f0 >= 16, 1'b1);
    $display("test queue done");
    print_verdict();
  end
endmodule : tb
